// *** hdl/nmt_pkg.sv ***
// Purpose: Shared constants and types for the network management slave
// Assumes: Frames arrive already decoded from the CAN controller
// Notes:   Identifiers are 11-bit standard identifiers
package nmt_pkg;
  localparam logic [10:0] ID_NMT        = 11'h000;
  localparam logic [10:0] ID_LSS_RX     = 11'h7e5;
  localparam logic [10:0] ID_LSS_TX     = 11'h7e4;
  localparam logic [10:0] ID_ERRCTL     = 11'h700;
  localparam logic [7:0]  CMD_START     = 8'h01;
  localparam logic [7:0]  CMD_STOP      = 8'h02;
  localparam logic [7:0]  CMD_PREOP     = 8'h80;
  localparam logic [7:0]  CMD_RST_NODE  = 8'h81;
  localparam logic [7:0]  CMD_RST_COMM  = 8'h82;
  localparam logic [7:0]  LSS_IDENT     = 8'h4c;
  localparam logic [7:0]  LSS_IDENT_ACK = 8'h50;
  localparam logic [7:0]  LSS_Q_NODE    = 8'h5e;
  localparam logic [7:0]  LSS_Q_SERIAL  = 8'h5d;
  localparam logic [7:0]  LSS_Q_REV     = 8'h5c;
  localparam logic [7:0]  LSS_Q_PROD    = 8'h5b;
  localparam logic [7:0]  LSS_Q_VENDOR  = 8'h5a;
  localparam logic [6:0]  CODE_BOOT     = 7'h00;
  localparam logic [6:0]  CODE_STOPPED  = 7'h04;
  localparam logic [6:0]  CODE_OPER     = 7'h05;
  localparam logic [6:0]  CODE_PREOP    = 7'h7f;
  // Guard time counts in milliseconds
  localparam int          MS_NS         = 1000000;
  localparam int          CLK_NS        = 20;
  localparam int          MS_CYCLES     = MS_NS / CLK_NS;
  localparam int          INIT_CYCLES   = 4;
  // AXI register byte addresses
  localparam logic [7:0]  A_CTRL        = 8'h00;
  localparam logic [7:0]  A_GUARD       = 8'h04;
  localparam logic [7:0]  A_HBEAT       = 8'h08;
  localparam logic [7:0]  A_STATUS      = 8'h0c;
  localparam logic [7:0]  A_SERIAL      = 8'h10;
  localparam logic [7:0]  A_REV         = 8'h14;
  localparam logic [7:0]  A_PROD        = 8'h18;
  localparam logic [7:0]  A_VENDOR      = 8'h1c;
  localparam logic [6:0]  RST_NODE_ID   = 7'h01;

  typedef enum logic [2:0] {
    ST_INIT    = 3'b000,
    ST_BOOT    = 3'b001,
    ST_PREOP   = 3'b010,
    ST_OPER    = 3'b011,
    ST_STOPPED = 3'b100
  } nmt_state_t;

  typedef struct packed {
    logic [10:0] id;
    logic        rtr;
    logic [63:0] data;
  } can_frame_t;
endpackage : nmt_pkg

// *** hdl/nmt_slave.sv ***
// Purpose: CANopen network management slave with LSS inquiry
// Assumes: CAN controller hands over whole frames, accepts one at a time
// Notes:   Registers on AXI4-Lite, 32-bit words
//
// Design decisions made here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module nmt_slave #(
  parameter int MS_PERIOD = nmt_pkg::MS_CYCLES
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                rx_valid,
  input  wire nmt_pkg::can_frame_t rx_frame,
  output logic                     tx_valid,
  output nmt_pkg::can_frame_t      tx_frame,
  input  wire logic                tx_ready,
  output logic                     pdo_enable,
  output logic                     emcy_enable,
  output logic                     sdo_enable,
  output logic                     params_default,
  input  wire logic [31:0]         s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [31:0]         s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready
);
  typedef struct packed {
    nmt_pkg::nmt_state_t state;
    logic [3:0]          init_cnt;
    logic                toggle;
    logic                guard_seen;
    logic [31:0]         life_ms;
    logic [15:0]         hb_ms;
    logic                tx_valid;
    nmt_pkg::can_frame_t tx_frame;
    logic                pdo_enable;
    logic                emcy_enable;
    logic                sdo_enable;
    logic                params_default;
    logic [6:0]          node_id;
    logic [15:0]         guard_time;
    logic [7:0]          life_factor;
    logic [15:0]         hb_time;
    logic [31:0]         serial;
    logic [31:0]         revision;
    logic [31:0]         product;
    logic [31:0]         vendor;
    logic                aw_held;
    logic                w_held;
    logic [7:0]          aw_addr;
    logic [31:0]         w_data;
    logic [3:0]          w_strb;
    logic                awready;
    logic                wready;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                arready;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
  } state_t;

  state_t st;
  state_t next_st;
  logic   ms_tick;

  nmt_tick #(.PERIOD(MS_PERIOD)) u_ms (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (ms_tick)
  );

  function automatic logic [6:0] code_of(input nmt_pkg::nmt_state_t s);
    case (s)
      nmt_pkg::ST_PREOP:   code_of = nmt_pkg::CODE_PREOP;
      nmt_pkg::ST_OPER:    code_of = nmt_pkg::CODE_OPER;
      nmt_pkg::ST_STOPPED: code_of = nmt_pkg::CODE_STOPPED;
      default:             code_of = nmt_pkg::CODE_BOOT;
    endcase
  endfunction

  function automatic logic [63:0] lss_reply(input logic [7:0] cs, input logic [31:0] v);
    lss_reply = {24'h0, v[31:24], v[23:16], v[15:8], v[7:0], cs};
  endfunction

  logic [7:0]  cmd;
  logic [7:0]  target;
  logic        running;
  logic        addressed;
  logic        guard_mode;
  logic [10:0] own_err_id;
  logic [31:0] rd_word;
  logic        rd_ok;
  logic [31:0] wmask;

  always_comb begin
    next_st    = st;
    cmd        = rx_frame.data[7:0];
    target     = rx_frame.data[15:8];
    running    = (st.state != nmt_pkg::ST_INIT) && (st.state != nmt_pkg::ST_BOOT);
    addressed  = rx_valid && !rx_frame.rtr && (rx_frame.id == nmt_pkg::ID_NMT) && running &&
                 (target == 8'({1'b0, st.node_id}) || target == 8'h00);
    guard_mode = (st.hb_time == 16'h0);
    own_err_id = nmt_pkg::ID_ERRCTL + {4'h0, st.node_id};
    next_st.params_default = 1'b0;

    if (st.tx_valid && tx_ready) begin
      next_st.tx_valid = 1'b0;
    end

    case (st.state)
      nmt_pkg::ST_INIT: begin
        next_st.toggle     = 1'b0;
        next_st.guard_seen = 1'b0;
        if (st.init_cnt == 4'(nmt_pkg::INIT_CYCLES - 1)) begin
          next_st.state = nmt_pkg::ST_BOOT;
        end else begin
          next_st.init_cnt = st.init_cnt + 4'h1;
        end
      end
      nmt_pkg::ST_BOOT: begin
        if (!st.tx_valid) begin
          next_st.tx_valid = 1'b1;
          next_st.tx_frame = '{id: own_err_id, rtr: 1'b0, data: 64'h0};
          next_st.state    = nmt_pkg::ST_PREOP;
        end
      end
      nmt_pkg::ST_PREOP, nmt_pkg::ST_OPER, nmt_pkg::ST_STOPPED: begin
        if (addressed) begin
          case (cmd)
            nmt_pkg::CMD_START: next_st.state = nmt_pkg::ST_OPER;
            nmt_pkg::CMD_STOP:  next_st.state = nmt_pkg::ST_STOPPED;
            nmt_pkg::CMD_PREOP: next_st.state = nmt_pkg::ST_PREOP;
            nmt_pkg::CMD_RST_NODE: begin
              next_st.params_default = 1'b1;
              next_st.guard_time     = 16'h0;
              next_st.life_factor    = 8'h0;
              next_st.hb_time        = 16'h0;
              next_st.state          = nmt_pkg::ST_INIT;
              next_st.init_cnt       = 4'h0;
            end
            nmt_pkg::CMD_RST_COMM: begin
              next_st.state    = nmt_pkg::ST_INIT;
              next_st.init_cnt = 4'h0;
            end
            default: ;
          endcase
        end else if (rx_valid && rx_frame.rtr && rx_frame.id == own_err_id && guard_mode &&
                     !st.tx_valid) begin
          // Guarding poll, answered also when stopped
          next_st.tx_valid   = 1'b1;
          next_st.tx_frame   = '{id: own_err_id, rtr: 1'b0,
                                 data: {56'h0, st.toggle, code_of(st.state)}};
          next_st.toggle     = ~st.toggle;
          next_st.guard_seen = 1'b1;
          next_st.life_ms    = 32'h0;
        end else if (rx_valid && !rx_frame.rtr && rx_frame.id == nmt_pkg::ID_LSS_RX &&
                     !st.tx_valid) begin
          next_st.tx_frame.id  = nmt_pkg::ID_LSS_TX;
          next_st.tx_frame.rtr = 1'b0;
          next_st.tx_valid     = 1'b1;
          case (cmd)
            nmt_pkg::LSS_IDENT:    next_st.tx_frame.data = {56'h0, nmt_pkg::LSS_IDENT_ACK};
            nmt_pkg::LSS_Q_NODE:   next_st.tx_frame.data = lss_reply(cmd, {25'h0, st.node_id});
            nmt_pkg::LSS_Q_SERIAL: next_st.tx_frame.data = lss_reply(cmd, st.serial);
            nmt_pkg::LSS_Q_REV:    next_st.tx_frame.data = lss_reply(cmd, st.revision);
            nmt_pkg::LSS_Q_PROD:   next_st.tx_frame.data = lss_reply(cmd, st.product);
            nmt_pkg::LSS_Q_VENDOR: next_st.tx_frame.data = lss_reply(cmd, st.vendor);
            default:               next_st.tx_valid = 1'b0;
          endcase
        end
        // Life-time supervision, armed by the first poll
        if (guard_mode && st.guard_seen && st.life_factor != 8'h0 && st.guard_time != 16'h0 &&
            next_st.life_ms != 32'h0 || (ms_tick && guard_mode && st.guard_seen)) begin
          if (ms_tick && next_st.life_ms == st.life_ms) begin
            next_st.life_ms = st.life_ms + 32'h1;
          end
          if (st.life_ms >= 32'(st.guard_time) * 32'(st.life_factor) && st.life_factor != 8'h0 &&
              st.guard_time != 16'h0 && !addressed) begin
            next_st.state      = nmt_pkg::ST_PREOP;
            next_st.guard_seen = 1'b0;
            next_st.life_ms    = 32'h0;
          end
        end
        // Heartbeat producer
        if (!guard_mode && ms_tick && !addressed) begin
          if (st.hb_ms + 16'h1 >= st.hb_time) begin
            next_st.hb_ms = 16'h0;
            if (!next_st.tx_valid) begin
              next_st.tx_valid = 1'b1;
              next_st.tx_frame = '{id: own_err_id, rtr: 1'b0,
                                   data: {57'h0, code_of(st.state)}};
            end
          end else begin
            next_st.hb_ms = st.hb_ms + 16'h1;
          end
        end
      end
      default: next_st.state = nmt_pkg::ST_INIT;
    endcase

    next_st.pdo_enable  = (next_st.state == nmt_pkg::ST_OPER);
    next_st.emcy_enable = (next_st.state == nmt_pkg::ST_OPER);
    next_st.sdo_enable  = (next_st.state == nmt_pkg::ST_PREOP) ||
                          (next_st.state == nmt_pkg::ST_OPER);

    // AXI4-Lite write path
    if (s_axi_awvalid && st.awready) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = s_axi_awaddr[7:0];
      next_st.awready = 1'b0;
    end
    if (s_axi_wvalid && st.wready) begin
      next_st.w_held = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
      next_st.wready = 1'b0;
    end
    wmask = {{8{st.w_strb[3]}}, {8{st.w_strb[2]}}, {8{st.w_strb[1]}}, {8{st.w_strb[0]}}};
    if (st.aw_held && st.w_held && !st.bvalid) begin
      next_st.bvalid = 1'b1;
      next_st.bresp  = 2'b00;
      case (st.aw_addr)
        nmt_pkg::A_CTRL:   next_st.node_id = (st.w_data[6:0] & wmask[6:0]) | (st.node_id & ~wmask[6:0]);
        nmt_pkg::A_GUARD: begin
          next_st.guard_time  = (st.w_data[15:0] & wmask[15:0]) | (st.guard_time & ~wmask[15:0]);
          next_st.life_factor = (st.w_data[23:16] & wmask[23:16]) | (st.life_factor & ~wmask[23:16]);
        end
        nmt_pkg::A_HBEAT:  next_st.hb_time  = (st.w_data[15:0] & wmask[15:0]) | (st.hb_time & ~wmask[15:0]);
        nmt_pkg::A_SERIAL: next_st.serial   = (st.w_data & wmask) | (st.serial & ~wmask);
        nmt_pkg::A_REV:    next_st.revision = (st.w_data & wmask) | (st.revision & ~wmask);
        nmt_pkg::A_PROD:   next_st.product  = (st.w_data & wmask) | (st.product & ~wmask);
        nmt_pkg::A_VENDOR: next_st.vendor   = (st.w_data & wmask) | (st.vendor & ~wmask);
        default:           next_st.bresp    = 2'b10;
      endcase
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid  = 1'b0;
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.awready = 1'b1;
      next_st.wready  = 1'b1;
    end

    // AXI4-Lite read path
    rd_ok = 1'b1;
    case (s_axi_araddr[7:0])
      nmt_pkg::A_CTRL:   rd_word = {25'h0, st.node_id};
      nmt_pkg::A_GUARD:  rd_word = {8'h0, st.life_factor, st.guard_time};
      nmt_pkg::A_HBEAT:  rd_word = {16'h0, st.hb_time};
      nmt_pkg::A_STATUS: rd_word = {23'h0, st.toggle, 1'b0, code_of(st.state)};
      nmt_pkg::A_SERIAL: rd_word = st.serial;
      nmt_pkg::A_REV:    rd_word = st.revision;
      nmt_pkg::A_PROD:   rd_word = st.product;
      nmt_pkg::A_VENDOR: rd_word = st.vendor;
      default: begin
        rd_word = 32'h0;
        rd_ok   = 1'b0;
      end
    endcase
    if (s_axi_arvalid && st.arready) begin
      next_st.arready = 1'b0;
      next_st.rvalid  = 1'b1;
      next_st.rdata   = rd_word;
      next_st.rresp   = rd_ok ? 2'b00 : 2'b10;
    end
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid  = 1'b0;
      next_st.arready = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st          <= '0;
      st.state    <= nmt_pkg::ST_INIT;
      st.node_id  <= nmt_pkg::RST_NODE_ID;
      st.awready  <= 1'b1;
      st.wready   <= 1'b1;
      st.arready  <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign tx_valid       = st.tx_valid;
  assign tx_frame       = st.tx_frame;
  assign pdo_enable     = st.pdo_enable;
  assign emcy_enable    = st.emcy_enable;
  assign sdo_enable     = st.sdo_enable;
  assign params_default = st.params_default;
  assign s_axi_awready  = st.awready;
  assign s_axi_wready   = st.wready;
  assign s_axi_bvalid   = st.bvalid;
  assign s_axi_bresp    = st.bresp;
  assign s_axi_arready  = st.arready;
  assign s_axi_rvalid   = st.rvalid;
  assign s_axi_rdata    = st.rdata;
  assign s_axi_rresp    = st.rresp;

  chk_start_oper: assert property (@(posedge aclk) disable iff (!aresetn)
    addressed && cmd == nmt_pkg::CMD_START |=> st.state == nmt_pkg::ST_OPER && pdo_enable && emcy_enable)
    else $error("start command did not enter operational");
  chk_stop_state: assert property (@(posedge aclk) disable iff (!aresetn)
    addressed && cmd == nmt_pkg::CMD_STOP |=> st.state == nmt_pkg::ST_STOPPED)
    else $error("stop command did not enter stopped");
  chk_preop_state: assert property (@(posedge aclk) disable iff (!aresetn)
    addressed && cmd == nmt_pkg::CMD_PREOP |=> st.state == nmt_pkg::ST_PREOP)
    else $error("pre-operational command ignored");
  chk_reset_init: assert property (@(posedge aclk) disable iff (!aresetn)
    addressed && cmd == nmt_pkg::CMD_RST_COMM |=> st.state == nmt_pkg::ST_INIT ##[1:8] tx_valid)
    else $error("communication reset did not reboot");
  chk_node_default: assert property (@(posedge aclk) disable iff (!aresetn)
    addressed && cmd == nmt_pkg::CMD_RST_NODE |=> params_default && st.hb_time == 16'h0)
    else $error("node reset did not restore defaults");
  chk_pdo_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    st.state != nmt_pkg::ST_OPER |-> !pdo_enable && !emcy_enable)
    else $error("process data enabled outside operational");
  chk_boot_frame: assert property (@(posedge aclk) disable iff (!aresetn)
    st.state == nmt_pkg::ST_BOOT && !st.tx_valid |=> tx_valid && tx_frame.data == 64'h0 &&
    tx_frame.id == nmt_pkg::ID_ERRCTL + {4'h0, st.node_id})
    else $error("boot-up frame malformed");
  chk_guard_toggle: assert property (@(posedge aclk) disable iff (!aresetn)
    st.state != nmt_pkg::ST_INIT && $changed(st.toggle) |-> tx_valid && tx_frame.data[7] == $past(st.toggle))
    else $error("toggle bit wrong in guarding reply");
  chk_ident_reply: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_valid && rx_frame.id == nmt_pkg::ID_LSS_RX && !rx_frame.rtr && cmd == nmt_pkg::LSS_IDENT &&
    running && !addressed && !tx_valid |=> tx_frame.id == nmt_pkg::ID_LSS_TX && tx_frame.data == 64'h50)
    else $error("identify reply malformed");
  cov_oper: cover property (@(posedge aclk) st.state == nmt_pkg::ST_OPER);
  cov_stopped: cover property (@(posedge aclk) st.state == nmt_pkg::ST_STOPPED);
  cov_timeout: cover property (@(posedge aclk) $fell(st.guard_seen) && st.state == nmt_pkg::ST_PREOP);
endmodule // nmt_slave
`default_nettype wire

// *** hdl/nmt_tick.sv ***
// Purpose: One-cycle enable pulse divider
// Assumes: Single clock domain
// Notes:   Period set by parameter
`timescale 1ns/10ps
`default_nettype none
module nmt_tick #(
  parameter int PERIOD = 50000
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  output logic      tick
);
  logic [31:0] count;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= 32'h0;
      tick  <= 1'b0;
    end else if (count == 32'(PERIOD - 1)) begin
      count <= 32'h0;
      tick  <= 1'b1;
    end else begin
      count <= count + 32'h1;
      tick  <= 1'b0;
    end
  end
endmodule // nmt_tick
`default_nettype wire

// *** sim/can_master_model.sv ***
// Purpose: CAN side partner, NMT and LSS master behind a CAN controller
// Assumes: Whole frames, one request per send call
// Notes:   slow holds tx_ready low three cycles in four
`timescale 1ns/10ps
`default_nettype none
module can_master_model (
  input  wire logic                aclk,
  input  wire logic                slow,
  output var  logic                rx_valid,
  output var  nmt_pkg::can_frame_t rx_frame,
  input  wire logic                tx_valid,
  input  wire nmt_pkg::can_frame_t tx_frame,
  output var  logic                tx_ready
);
  logic [1:0]          phase    = 2'h0;
  int                  tx_count = 0;
  nmt_pkg::can_frame_t last_tx  = '0;
  initial begin
    rx_valid = 1'b0;
    rx_frame = '0;
  end
  always @(posedge aclk) begin
    phase    <= phase + 2'h1;
    tx_ready <= !slow || (phase == 2'h3);
    if (tx_valid && tx_ready) begin
      tx_count <= tx_count + 1;
      last_tx  <= tx_frame;
    end
  end
  // One frame per call; released lines show the inverse
  task automatic send(input logic [10:0] id, input logic rtr, input logic [63:0] data);
    @(posedge aclk);
    rx_valid <= 1'b1;
    rx_frame <= {id, rtr, data};
    @(posedge aclk);
    rx_valid <= 1'b0;
    rx_frame <= ~rx_frame;
  endtask
endmodule // can_master_model
`default_nettype wire

// *** sim/tb.sv ***
// Purpose: Self-checking bench for the network management slave
// Assumes: Millisecond tick shortened to 10 cycles
// Notes:   Frames through the partner model, registers over AXI4-Lite
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic                aclk, aresetn, slow, rx_valid, tx_valid, tx_ready;
  nmt_pkg::can_frame_t rx_frame, tx_frame, f;
  logic                pdo_enable, emcy_enable, sdo_enable, params_default;
  logic [31:0]         s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]          s_axi_wstrb;
  logic                s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic                s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, tog;
  logic [1:0]          s_axi_bresp, s_axi_rresp;
  logic [7:0]          cmds [5] = '{8'h5e, 8'h5d, 8'h5c, 8'h5b, 8'h5a};
  int                  bad_count, num_checks, polls, n0;
  int                  pulses = 0;

  nmt_slave #(.MS_PERIOD(10)) u_dut (.aclk, .aresetn, .rx_valid, .rx_frame, .tx_valid, .tx_frame, .tx_ready,
    .pdo_enable, .emcy_enable, .sdo_enable, .params_default, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  can_master_model u_mst (.aclk, .slow, .rx_valid, .rx_frame, .tx_valid, .tx_frame, .tx_ready);

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (params_default === 1'b1) pulses++;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic timeout();
    bad_count++;
    print_verdict();
  endtask
  task automatic wait_tx(input int n);
    int i;
    for (i = 0; i < 300 && u_mst.tx_count == n; i++) @(posedge aclk);
    if (i == 300) timeout();
    f = u_mst.last_tx;
  endtask
  task automatic xfer(input logic [10:0] id, input logic rtr, input logic [63:0] d);
    n0 = u_mst.tx_count;
    u_mst.send(id, rtr, d);
    wait_tx(n0);
  endtask
  task automatic nmt(input logic [7:0] cmd, input logic [7:0] node);
    u_mst.send(nmt_pkg::ID_NMT, 1'b0, {48'h0, node, cmd});
    repeat (3) @(posedge aclk);
  endtask
  task automatic poll(input logic [6:0] code);
    xfer(nmt_pkg::ID_ERRCTL + 11'h1, 1'b1, 64'h0);
    check(64'(f.id), 64'h701);
    check(f.data & ~64'h80, 64'(code));
    if (polls > 0) check(64'(f.data[7]), {63'h0, ~tog});
    tog = f.data[7];
    polls++;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int i;
    @(posedge aclk);
    s_axi_awaddr  <= {24'h0, a};
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    if (i == 100) timeout();
    check(64'(s_axi_bresp), 64'(er));
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int i;
    @(posedge aclk);
    s_axi_araddr  <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    if (i == 100) timeout();
    check(64'(s_axi_rdata), 64'(ed));
    check(64'(s_axi_rresp), 64'(er));
  endtask

  initial begin
    {aresetn, slow, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    s_axi_wstrb = 4'hf;
    {bad_count, num_checks, polls} = '0;
    tog = 1'b0;
    repeat (12) @(posedge aclk);
    n0 = u_mst.tx_count;
    aresetn <= 1'b1;
    wait_tx(n0);
    check(64'(f.id), 64'h701);
    check(f.data, 64'h0);
    check(64'({pdo_enable, emcy_enable, sdo_enable}), 64'h1);
    axi_rd(nmt_pkg::A_CTRL, 32'h1, 2'h0);
    axi_rd(8'h40, 32'h0, 2'h2);
    axi_wr(8'h40, 32'h5, 2'h2);
    $display("test boot done");
    poll(7'h7f);
    nmt(nmt_pkg::CMD_START, 8'h1);
    check(64'({pdo_enable, emcy_enable, sdo_enable}), 64'h7);
    poll(7'h05);
    nmt(nmt_pkg::CMD_STOP, 8'h0);
    check(64'({pdo_enable, emcy_enable, sdo_enable}), 64'h0);
    poll(7'h04);
    nmt(nmt_pkg::CMD_PREOP, 8'h2);
    poll(7'h04);
    nmt(nmt_pkg::CMD_PREOP, 8'h1);
    poll(7'h7f);
    check(64'({pdo_enable, sdo_enable}), 64'h1);
    $display("test states done");
    slow <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      if (i > 0) axi_wr(nmt_pkg::A_SERIAL + 8'(4 * (i - 1)), 32'ha1b2c3d4 ^ i, 2'h0);
      xfer(nmt_pkg::ID_LSS_RX, 1'b0, {56'h0, cmds[i]});
      check(64'(f.id), 64'h7e4);
      check(f.data, {24'h0, (i == 0) ? 32'h1 : 32'ha1b2c3d4 ^ i, cmds[i]});
    end
    xfer(nmt_pkg::ID_LSS_RX, 1'b0, 64'h4c);
    check(f.data, 64'h50);
    slow <= 1'b0;
    $display("test lss done");
    axi_wr(nmt_pkg::A_GUARD, 32'h0002_0001, 2'h0);
    nmt(nmt_pkg::CMD_START, 8'h1);
    poll(7'h05);
    repeat (100) @(posedge aclk);
    check(64'(pdo_enable), 64'h0);
    axi_wr(nmt_pkg::A_HBEAT, 32'h1, 2'h0);
    wait_tx(u_mst.tx_count);
    check(f.data & 64'h7f, 64'h7f);
    axi_wr(nmt_pkg::A_HBEAT, 32'h0, 2'h0);
    repeat (30) @(posedge aclk);
    $display("test guard done");
    xfer(nmt_pkg::ID_NMT, 1'b0, {48'h0, 8'h1, nmt_pkg::CMD_RST_COMM});
    check(f.data, 64'h0);
    xfer(nmt_pkg::ID_NMT, 1'b0, {48'h0, 8'h0, nmt_pkg::CMD_RST_NODE});
    check(64'(f.id), 64'h701);
    check(64'(pulses), 64'h1);
    axi_rd(nmt_pkg::A_GUARD, 32'h0, 2'h0);
    axi_rd(nmt_pkg::A_STATUS, 32'h7f, 2'h0);
    $display("test resets done");
    print_verdict();
  end
endmodule // tb
`default_nettype wire
